// ==== shared/radio_cfg_regs.svh ====
// Purpose: register indices, reset values, fields and codes of the loader
// Assumes: byte address on the bus is four times the register index
// Notes: definitions only
`ifndef RADIO_CFG_REGS_SVH
`define RADIO_CFG_REGS_SVH
`define IDX_TX_PREAMBLE_LENGTH 10'h102
`define IDX_SYNC_BYTE_LOW 10'h10c
`define IDX_SYNC_BYTE_MID 10'h10d
`define IDX_SYNC_BYTE_HIGH 10'h10e
`define IDX_SYNC_LENGTH_TOLERANCE 10'h10f
`define IDX_RADIO_CONTROLLER_MODE_SELECT 10'h13e
`define IDX_TX_FREQUENCY_DEVIATION 10'h304
`define IDX_DISCRIMINATOR_BANDWIDTH 10'h305
`define IDX_TX_MODULATION_FILTER 10'h306
`define IDX_BIT_RATE_HIGH_BYTE 10'h30e
`define IDX_BIT_RATE_LOW_BYTE 10'h30f
`define IDX_SERIAL_PORT_PIN_SETUP 10'h32c
`define IDX_PLL_SETTLE_TIME 10'h335
`define IDX_DIGITAL_IF_FILTER_SETTING 10'h389
`define IDX_POSTDEMOD_BANDWIDTH 10'h38b
`define IDX_RECEIVE_FRONT_END_SETUP 10'h39b
`define IDX_GAIN_CONTROL_LOCK 10'h3b2
`define IDX_GAIN_CONTROL_CEILING 10'h3b4
`define IDX_GAIN_CONTROL_SETTING_2 10'h3b6
`define IDX_GAIN_CONTROL_SETTING_3 10'h3b7
`define IDX_GAIN_CONTROL_SETTING_4 10'h3b8
`define IDX_GAIN_CONTROL_SETTING_6 10'h3ba
`define IDX_GAIN_CONTROL_SETTING_7 10'h3bc
`define IDX_OFFSET_LOOP_SETTING_0 10'h3bf
`define IDX_OFFSET_LOOP_SETTING_1 10'h3c4
`define IDX_OFFSET_LOOP_BANDWIDTH_0 10'h3d2
`define IDX_OFFSET_LOOP_BANDWIDTH_1 10'h3d3
`define IDX_OFFSET_LOOP_BANDWIDTH_2 10'h3d4
`define IDX_OFFSET_LOOP_BANDWIDTH_3 10'h3d5
`define IDX_OFFSET_LOOP_BANDWIDTH_4 10'h3d6
`define IDX_OFFSET_LOOP_BANDWIDTH_SELECT 10'h3d7
`define IDX_OFFSET_LOOP_BANDWIDTH_13 10'h3e0
`define IDX_PREAMBLE_CHECK_COUNT 10'h3f3
`define IDX_FREQ_CORRECTION_SETUP 10'h3f7
`define IDX_FREQ_CORRECTION_GAINS 10'h3f8
`define IDX_FREQ_CORRECTION_PULL_RANGE 10'h3f9
`define IDX_LOADER_STATUS 10'h3fe
`define IDX_RADIO_CONTROLLER_RESET_COMMAND 10'h3ff
`define RST_RECEIVE_FRONT_END_SETUP 8'h10
`define RST_PREAMBLE_CHECK_COUNT 8'h05
`define RST_OTHER 8'h00
`define MODE_FSK_PACKET 8'h04
`define MODE_FSK_STREAM 8'h03
`define FREQ_CORRECTION_ON 8'h07
`define RESET_COMMAND_CODE 8'h01
`define PREAMBLE_EXTRA_BYTES 9'h002
`define RATE_UNIT_BPS 8'h64
`define LNA_SEL_LSB 4
`define LNA_SEL_MSB 6
`define BB_BW_MSB 3
`define SYNC_TOL_LSB 5
`define SYNC_TOL_MSB 6
`define SYNC_LEN_MSB 4
`define SYNC_MAX_BITS 5'h18
`define STAT_FAMILY_ERR_BIT 0
`define STAT_FSK_FAMILY_BIT 1
`define STAT_RESET_SEEN_BIT 2
`endif

// ==== shared/radio_cfg_pkg.sv ====
// Purpose: types shared by the configuration loader
// Assumes: nothing
// Notes: decoded settings travel as one packed struct
package radio_cfg_pkg;
  typedef struct packed {
    logic fsk_packet_mode;
    logic bit_stream_serial_port;
    logic fsk_family;
    logic [8:0] tx_preamble_total;
    logic [23:0] sync_word;
    logic [4:0] sync_length;
    logic [1:0] sync_tolerance;
    logic freq_correction_enable;
    logic [7:0] freq_correction_gains;
    logic [7:0] freq_correction_pull_range;
    logic [2:0] lna_select;
    logic [3:0] analog_baseband_bandwidth;
    logic [23:0] bit_rate_bps;
  } cfg_s;
  typedef enum logic [1:0] {
    FAM_UNSET = 2'b00,
    FAM_FSK = 2'b01,
    FAM_STD = 2'b10
  } family_e;
endpackage

// ==== rtl/radio_mode_config_loader.sv ====
// Purpose: register file and decoder for the transceiver mode settings
// Assumes: Avalon-MM slave, byte addresses, register index = address / 4
// Notes: each register is 8 bits in the low lane, upper bits read as zero

`include "radio_cfg_regs.svh"

module radio_mode_config_loader
  import radio_cfg_pkg::*;
#(
  parameter int NREG = 36
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output cfg_s CFG,
  output logic RADIO_CONTROLLER_RESET_COMMAND_PULSE
);

  logic [7:0] regs_q [0:NREG-1];
  logic ack_q;
  logic [31:0] rdata_q;
  logic [9:0] idx;
  logic [5:0] slot;
  logic req;
  logic wr_fire;
  logic wr_lane;
  logic fam_err_q;
  logic reset_seen_q;
  logic rc_pulse_q;
  family_e fam_q;
  family_e new_fam;
  cfg_s cfg_d;
  cfg_s cfg_q;
  logic [23:0] sync_mask;
  logic [15:0] rate_word;
  logic [7:0] status_v;
  logic mapped;
  logic rd_take;
  logic wr_mode;
  logic wr_status;
  logic wr_cmd;

  logic [7:0] preamble_len_v;
  logic [7:0] sync_low_v;
  logic [7:0] sync_mid_v;
  logic [7:0] sync_high_v;
  logic [7:0] sync_cfg_v;
  logic [4:0] sync_len_v;
  logic [7:0] mode_sel_v;
  logic [7:0] rate_high_v;
  logic [7:0] rate_low_v;
  logic [7:0] rx_front_v;
  logic [7:0] afc_setup_v;
  logic [7:0] afc_gain_v;
  logic [7:0] afc_range_v;

  function automatic logic [5:0] slot_of(input logic [9:0] a);
    case (a)
      `IDX_TX_PREAMBLE_LENGTH: slot_of = 6'h00;

      `IDX_SYNC_BYTE_LOW: slot_of = 6'h01;
      `IDX_SYNC_BYTE_MID: slot_of = 6'h02;
      `IDX_SYNC_BYTE_HIGH: slot_of = 6'h03;
      `IDX_SYNC_LENGTH_TOLERANCE: slot_of = 6'h04;

      `IDX_RADIO_CONTROLLER_MODE_SELECT: slot_of = 6'h05;

      `IDX_TX_FREQUENCY_DEVIATION: slot_of = 6'h06;
      `IDX_DISCRIMINATOR_BANDWIDTH: slot_of = 6'h07;
      `IDX_TX_MODULATION_FILTER: slot_of = 6'h08;

      `IDX_BIT_RATE_HIGH_BYTE: slot_of = 6'h09;
      `IDX_BIT_RATE_LOW_BYTE: slot_of = 6'h0a;

      `IDX_SERIAL_PORT_PIN_SETUP: slot_of = 6'h0b;
      `IDX_PLL_SETTLE_TIME: slot_of = 6'h0c;

      `IDX_DIGITAL_IF_FILTER_SETTING: slot_of = 6'h0d;
      `IDX_POSTDEMOD_BANDWIDTH: slot_of = 6'h0e;
      `IDX_RECEIVE_FRONT_END_SETUP: slot_of = 6'h0f;

      `IDX_GAIN_CONTROL_LOCK: slot_of = 6'h10;
      `IDX_GAIN_CONTROL_CEILING: slot_of = 6'h11;
      `IDX_GAIN_CONTROL_SETTING_2: slot_of = 6'h12;
      `IDX_GAIN_CONTROL_SETTING_3: slot_of = 6'h13;
      `IDX_GAIN_CONTROL_SETTING_4: slot_of = 6'h14;
      `IDX_GAIN_CONTROL_SETTING_6: slot_of = 6'h15;
      `IDX_GAIN_CONTROL_SETTING_7: slot_of = 6'h16;

      `IDX_OFFSET_LOOP_SETTING_0: slot_of = 6'h17;
      `IDX_OFFSET_LOOP_SETTING_1: slot_of = 6'h18;
      `IDX_OFFSET_LOOP_BANDWIDTH_0: slot_of = 6'h19;
      `IDX_OFFSET_LOOP_BANDWIDTH_1: slot_of = 6'h1a;
      `IDX_OFFSET_LOOP_BANDWIDTH_2: slot_of = 6'h1b;
      `IDX_OFFSET_LOOP_BANDWIDTH_3: slot_of = 6'h1c;
      `IDX_OFFSET_LOOP_BANDWIDTH_4: slot_of = 6'h1d;
      `IDX_OFFSET_LOOP_BANDWIDTH_SELECT: slot_of = 6'h1e;
      `IDX_OFFSET_LOOP_BANDWIDTH_13: slot_of = 6'h1f;

      `IDX_PREAMBLE_CHECK_COUNT: slot_of = 6'h20;
      `IDX_FREQ_CORRECTION_SETUP: slot_of = 6'h21;
      `IDX_FREQ_CORRECTION_GAINS: slot_of = 6'h22;
      `IDX_FREQ_CORRECTION_PULL_RANGE: slot_of = 6'h23;

      default: slot_of = 6'h3f;
    endcase
  endfunction

  function automatic logic [7:0] reset_of(input logic [5:0] s);
    case (s)
      slot_of(`IDX_TX_PREAMBLE_LENGTH): reset_of = `RST_OTHER;

      slot_of(`IDX_SYNC_BYTE_LOW): reset_of = `RST_OTHER;
      slot_of(`IDX_SYNC_BYTE_MID): reset_of = `RST_OTHER;
      slot_of(`IDX_SYNC_BYTE_HIGH): reset_of = `RST_OTHER;
      slot_of(`IDX_SYNC_LENGTH_TOLERANCE): reset_of = `RST_OTHER;

      slot_of(`IDX_RADIO_CONTROLLER_MODE_SELECT): reset_of = `RST_OTHER;

      slot_of(`IDX_TX_FREQUENCY_DEVIATION): reset_of = `RST_OTHER;
      slot_of(`IDX_DISCRIMINATOR_BANDWIDTH): reset_of = `RST_OTHER;
      slot_of(`IDX_TX_MODULATION_FILTER): reset_of = `RST_OTHER;

      slot_of(`IDX_BIT_RATE_HIGH_BYTE): reset_of = `RST_OTHER;
      slot_of(`IDX_BIT_RATE_LOW_BYTE): reset_of = `RST_OTHER;

      slot_of(`IDX_SERIAL_PORT_PIN_SETUP): reset_of = `RST_OTHER;
      slot_of(`IDX_PLL_SETTLE_TIME): reset_of = `RST_OTHER;
      slot_of(`IDX_DIGITAL_IF_FILTER_SETTING): reset_of = `RST_OTHER;
      slot_of(`IDX_POSTDEMOD_BANDWIDTH): reset_of = `RST_OTHER;

      slot_of(`IDX_RECEIVE_FRONT_END_SETUP):
        reset_of = `RST_RECEIVE_FRONT_END_SETUP;

      slot_of(`IDX_GAIN_CONTROL_LOCK): reset_of = `RST_OTHER;
      slot_of(`IDX_GAIN_CONTROL_CEILING): reset_of = `RST_OTHER;
      slot_of(`IDX_GAIN_CONTROL_SETTING_2): reset_of = `RST_OTHER;
      slot_of(`IDX_GAIN_CONTROL_SETTING_3): reset_of = `RST_OTHER;
      slot_of(`IDX_GAIN_CONTROL_SETTING_4): reset_of = `RST_OTHER;
      slot_of(`IDX_GAIN_CONTROL_SETTING_6): reset_of = `RST_OTHER;
      slot_of(`IDX_GAIN_CONTROL_SETTING_7): reset_of = `RST_OTHER;

      slot_of(`IDX_OFFSET_LOOP_SETTING_0): reset_of = `RST_OTHER;
      slot_of(`IDX_OFFSET_LOOP_SETTING_1): reset_of = `RST_OTHER;
      slot_of(`IDX_OFFSET_LOOP_BANDWIDTH_0): reset_of = `RST_OTHER;
      slot_of(`IDX_OFFSET_LOOP_BANDWIDTH_1): reset_of = `RST_OTHER;
      slot_of(`IDX_OFFSET_LOOP_BANDWIDTH_2): reset_of = `RST_OTHER;
      slot_of(`IDX_OFFSET_LOOP_BANDWIDTH_3): reset_of = `RST_OTHER;
      slot_of(`IDX_OFFSET_LOOP_BANDWIDTH_4): reset_of = `RST_OTHER;
      slot_of(`IDX_OFFSET_LOOP_BANDWIDTH_SELECT): reset_of = `RST_OTHER;
      slot_of(`IDX_OFFSET_LOOP_BANDWIDTH_13): reset_of = `RST_OTHER;

      slot_of(`IDX_PREAMBLE_CHECK_COUNT): reset_of = `RST_PREAMBLE_CHECK_COUNT;

      slot_of(`IDX_FREQ_CORRECTION_SETUP): reset_of = `RST_OTHER;
      slot_of(`IDX_FREQ_CORRECTION_GAINS): reset_of = `RST_OTHER;
      slot_of(`IDX_FREQ_CORRECTION_PULL_RANGE): reset_of = `RST_OTHER;
      default: reset_of = `RST_OTHER;
    endcase
  endfunction

  function automatic family_e family_of(input logic [7:0] m);
    if (m == `MODE_FSK_PACKET || m == `MODE_FSK_STREAM) begin
      family_of = FAM_FSK;
    end else begin
      family_of = FAM_STD;
    end
  endfunction

  assign idx = AVS_ADDRESS[11:2];
  assign slot = slot_of(idx);
  assign req = AVS_READ | AVS_WRITE;
  assign wr_lane = AVS_WRITE & AVS_BYTEENABLE[0];
  assign wr_fire = wr_lane & ack_q;
  assign new_fam = family_of(AVS_WRITEDATA[7:0]);
  assign mapped = slot < NREG[5:0];
  assign rd_take = AVS_READ & ~ack_q;
  assign wr_mode = wr_fire && idx == `IDX_RADIO_CONTROLLER_MODE_SELECT;
  assign wr_status = wr_fire && idx == `IDX_LOADER_STATUS;
  assign wr_cmd = wr_fire && idx == `IDX_RADIO_CONTROLLER_RESET_COMMAND;

  // named views of the stored registers
  assign preamble_len_v = regs_q[slot_of(`IDX_TX_PREAMBLE_LENGTH)];
  assign sync_low_v = regs_q[slot_of(`IDX_SYNC_BYTE_LOW)];
  assign sync_mid_v = regs_q[slot_of(`IDX_SYNC_BYTE_MID)];
  assign sync_high_v = regs_q[slot_of(`IDX_SYNC_BYTE_HIGH)];
  assign sync_cfg_v = regs_q[slot_of(`IDX_SYNC_LENGTH_TOLERANCE)];
  assign sync_len_v = sync_cfg_v[`SYNC_LEN_MSB:0];

  assign mode_sel_v = regs_q[slot_of(`IDX_RADIO_CONTROLLER_MODE_SELECT)];
  assign rate_high_v = regs_q[slot_of(`IDX_BIT_RATE_HIGH_BYTE)];
  assign rate_low_v = regs_q[slot_of(`IDX_BIT_RATE_LOW_BYTE)];
  assign rx_front_v = regs_q[slot_of(`IDX_RECEIVE_FRONT_END_SETUP)];

  assign afc_setup_v = regs_q[slot_of(`IDX_FREQ_CORRECTION_SETUP)];
  assign afc_gain_v = regs_q[slot_of(`IDX_FREQ_CORRECTION_GAINS)];
  assign afc_range_v = regs_q[slot_of(`IDX_FREQ_CORRECTION_PULL_RANGE)];

  // one wait cycle, then the answer
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign AVS_READDATA = rdata_q;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // status word of the loader
  always_comb begin
    status_v = `RST_OTHER;
    status_v[`STAT_FAMILY_ERR_BIT] = fam_err_q;
    status_v[`STAT_FSK_FAMILY_BIT] = (fam_q == FAM_FSK);
    status_v[`STAT_RESET_SEEN_BIT] = reset_seen_q;
  end

  // read data captured in the wait cycle, stands at the answering edge
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_q <= 32'h0000_0000;
      if (mapped) begin
        rdata_q[7:0] <= regs_q[slot];
      end else if (idx == `IDX_LOADER_STATUS) begin
        rdata_q[7:0] <= status_v;
      end
    end
  end

  // register file, written at the answering edge only
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= reset_of(6'(i));
      end
    end else if (wr_fire && mapped) begin
      regs_q[slot] <= AVS_WRITEDATA[7:0];
    end
  end

  // controller reset command pulse
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rc_pulse_q <= 1'b0;
    end else begin
      rc_pulse_q <= wr_cmd &&
                    AVS_WRITEDATA[7:0] == `RESET_COMMAND_CODE;
    end
  end
  assign RADIO_CONTROLLER_RESET_COMMAND_PULSE = rc_pulse_q;

  // family tracking: a change of family needs a reset command first
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      fam_q <= FAM_UNSET;
      reset_seen_q <= 1'b0;
    end else if (rc_pulse_q) begin
      reset_seen_q <= 1'b1;
    end else if (wr_mode) begin
      fam_q <= new_fam;
      reset_seen_q <= 1'b0;
    end
  end

  // sticky error; a new error wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      fam_err_q <= 1'b0;
    end else if (wr_mode && fam_q != FAM_UNSET && new_fam != fam_q &&
                 !reset_seen_q) begin
      fam_err_q <= 1'b1;
    end else if (wr_status && AVS_WRITEDATA[`STAT_FAMILY_ERR_BIT]) begin
      fam_err_q <= 1'b0;
    end
  end

  // sync mask from the programmed length
  always_comb begin
    if (sync_len_v >= `SYNC_MAX_BITS) begin
      sync_mask = 24'hff_ffff;
    end else begin
      sync_mask = 24'((25'h000_0001 << sync_len_v) - 25'h000_0001);
    end
  end

  assign rate_word = {rate_high_v, rate_low_v};

  // decode of the stored settings
  always_comb begin
    cfg_d = '0;
    cfg_d.fsk_packet_mode = (mode_sel_v == `MODE_FSK_PACKET);
    cfg_d.bit_stream_serial_port = (mode_sel_v == `MODE_FSK_STREAM);
    cfg_d.fsk_family = (fam_q == FAM_FSK);

    cfg_d.tx_preamble_total = {1'b0, preamble_len_v}
                              + `PREAMBLE_EXTRA_BYTES;

    cfg_d.sync_word = {sync_high_v, sync_mid_v, sync_low_v}
                      & sync_mask;
    cfg_d.sync_length = sync_len_v;
    cfg_d.sync_tolerance = sync_cfg_v[`SYNC_TOL_MSB:`SYNC_TOL_LSB];

    cfg_d.freq_correction_enable =
      (afc_setup_v == `FREQ_CORRECTION_ON);
    cfg_d.freq_correction_gains = afc_gain_v;
    cfg_d.freq_correction_pull_range = afc_range_v;

    cfg_d.lna_select = rx_front_v[`LNA_SEL_MSB:`LNA_SEL_LSB];
    cfg_d.analog_baseband_bandwidth = rx_front_v[`BB_BW_MSB:0];
    // product kept at full output width so fast rates do not wrap
    cfg_d.bit_rate_bps = 24'(rate_word) * 24'(`RATE_UNIT_BPS);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end
  assign CFG = cfg_q;

endmodule // radio_mode_config_loader

// ==== sim/radio_mode_config_loader_chk.sv ====
// Purpose: port assertions for the mode loader
// Assumes: CFG shows a taken write two edges after the answering edge
// Notes: bound to every loader instance
module radio_mode_config_loader_chk
  import radio_cfg_pkg::*;
#(
  parameter int NREG = 36
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire cfg_s CFG,
  input wire logic RADIO_CONTROLLER_RESET_COMMAND_PULSE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  sequence wr_s(logic [9:0] i);
    AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
      && AVS_ADDRESS[11:2] == i;
  endsequence
  sequence pulse_s;
    RADIO_CONTROLLER_RESET_COMMAND_PULSE ##1 !RADIO_CONTROLLER_RESET_COMMAND_PULSE;
  endsequence
  one_wait_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("request waited too long");
  preamble_total_a: assert property (wr_s(10'h102) |-> ##2
    CFG.tx_preamble_total == $past(AVS_WRITEDATA[7:0], 2) + 9'd2)
    else $error("preamble total wrong");
  mode_decode_a: assert property (wr_s(10'h13e) |-> ##2
    CFG.fsk_packet_mode == ($past(AVS_WRITEDATA[7:0], 2) == 8'h04) &&
    CFG.bit_stream_serial_port == ($past(AVS_WRITEDATA[7:0], 2) == 8'h03))
    else $error("mode decode wrong");
  sync_mask_a: assert property (CFG.sync_length == 5'h10
    |-> CFG.sync_word[23:16] == 8'h00) else $error("sync mask wrong");
  sync_tol_a: assert property (wr_s(10'h10f) |-> ##2
    CFG.sync_tolerance == $past(AVS_WRITEDATA[6:5], 2))
    else $error("sync tolerance wrong");
  afc_enable_a: assert property (wr_s(10'h3f7) |-> ##2
    CFG.freq_correction_enable == ($past(AVS_WRITEDATA[7:0], 2) == 8'h07))
    else $error("correction enable wrong");
  pull_range_a: assert property (wr_s(10'h3f9) |-> ##2
    CFG.freq_correction_pull_range == $past(AVS_WRITEDATA[7:0], 2))
    else $error("pull range wrong");
  lna_select_a: assert property (wr_s(10'h39b) |-> ##2
    CFG.lna_select == $past(AVS_WRITEDATA[6:4], 2))
    else $error("port select wrong");
  reset_pulse_a: assert property (AVS_WRITEDATA[7:0] == 8'h01
    ##0 wr_s(10'h3ff) |=> pulse_s) else $error("reset pulse wrong");
endmodule // radio_mode_config_loader_chk

bind radio_mode_config_loader radio_mode_config_loader_chk
  #(.NREG(NREG)) chk (
  .CORE_CLK(CORE_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .CFG(CFG), .RADIO_CONTROLLER_RESET_COMMAND_PULSE(RADIO_CONTROLLER_RESET_COMMAND_PULSE));

// ==== sim/radio_mode_config_loader_tb.sv ====
// Purpose: register-level bench for the mode loader
// Assumes: master waits on waitrequest, CFG settles within two edges
// Notes: fixed stimulus tables only
module radio_mode_config_loader_tb
  import radio_cfg_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, rd, wr, wq, pls;
  logic [11:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] be;
  cfg_s cfg;
  int fails, n_compared, npls;
  logic [7:0] pre [4] = '{8'h04, 8'h05, 8'h07, 8'h09};
  logic [15:0] rate [8] = '{16'h01f4, 16'h0271, 16'h03e8, 16'h04e2,
    16'h09c4, 16'h1388, 16'h2710, 16'h4e20};
  radio_mode_config_loader uut (
    .CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .CFG(cfg),
    .RADIO_CONTROLLER_RESET_COMMAND_PULSE(pls));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pls === 1'b1) npls <= npls + 1;
  end
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // one access, held until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [9:0] i,
    input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    adr <= {i, 2'b00};
    wr <= w;
    rd <= !w;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (wq !== 1'b0) begin
      fails++;
      finish_test();
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic w8(input logic [9:0] i, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, i, d, q);
  endtask
  task automatic r8(input logic [9:0] i, input logic [7:0] e);
    logic [31:0] q;
    acc(1'b0, i, 8'h00, q);
    chk(q, {24'h0, e});
  endtask
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = '0;
    wdat = '0;
    be = 4'hf;
    npls = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    r8(10'h39b, 8'h10);
    r8(10'h3f3, 8'h05);
    chk(cfg.lna_select, 1);
    chk(cfg.tx_preamble_total, 2);
    w8(10'h13e, 8'h04);
    for (int k = 0; k < 4; k++) begin
      w8(10'h102, pre[k]);
      chk(cfg.tx_preamble_total, pre[k] + 9'd2);
    end
    r8(10'h102, 8'h09);
    for (int k = 0; k < 8; k++) begin
      w8(10'h30e, rate[k][15:8]);
      w8(10'h30f, rate[k][7:0]);
      w8(10'h39b, {4'h1, (k == 7) ? 4'hd : 4'h6});
      chk(cfg.bit_rate_bps, rate[k] * 24'd100);
      chk(cfg.analog_baseband_bandwidth, (k == 7) ? 4'hd : 4'h6);
    end
    w8(10'h39b, 8'h06);
    chk(cfg.lna_select, 0);
    w8(10'h13e, 8'h04);
    chk({cfg.fsk_packet_mode, cfg.bit_stream_serial_port}, 2'b10);
    chk(cfg.fsk_family, 1);
    w8(10'h13e, 8'h03);
    chk({cfg.fsk_packet_mode, cfg.bit_stream_serial_port}, 2'b01);
    w8(10'h10c, 8'h31);
    w8(10'h10d, 8'h7f);
    w8(10'h10e, 8'haa);
    w8(10'h10f, 8'h10);
    chk(cfg.sync_word, 24'h007f31);
    chk(cfg.sync_tolerance, 0);
    chk(cfg.sync_length, 5'h10);
    w8(10'h10f, 8'h78);
    chk(cfg.sync_word, 24'haa7f31);
    chk(cfg.sync_tolerance, 3);
    w8(10'h3f7, 8'h07);
    chk(cfg.freq_correction_enable, 1);
    w8(10'h3f8, 8'h99);
    chk(cfg.freq_correction_gains, 8'h99);
    w8(10'h3f9, 8'h50);
    chk(cfg.freq_correction_pull_range, 8'h50);
    w8(10'h3f7, 8'h06);
    chk(cfg.freq_correction_enable, 0);
    be <= 4'he;
    w8(10'h3f9, 8'h11);
    be <= 4'hf;
    r8(10'h3f9, 8'h50);
    w8(10'h000, 8'h5a);
    r8(10'h000, 8'h00);
    w8(10'h13e, 8'h00);
    chk(cfg.fsk_family, 0);
    r8(10'h3fe, 8'h01);
    w8(10'h306, 8'h01);
    r8(10'h306, 8'h01);
    w8(10'h32c, 8'h05);
    r8(10'h32c, 8'h05);
    w8(10'h3fe, 8'h01);
    w8(10'h3ff, 8'h01);
    r8(10'h3fe, 8'h04);
    w8(10'h13e, 8'h04);
    r8(10'h3fe, 8'h02);
    chk(npls, 1);
    finish_test();
  end
endmodule // radio_mode_config_loader_tb
